// File: hw/pcicx_pkg.sv
/*
 * Constants and carrier types for the configuration extension registers:
 * offsets, field positions, fixed read values and the bus request struct.
 * Assumes byte addresses on the configuration port, one 32-bit word each.
 */
package pcicx_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int CFG_ADDR_W = 8;
   localparam int DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CMD_STATUS = 8'h04;
   localparam logic [7:0] OFF_IO_BASE = 8'h14;
   localparam logic [7:0] OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] OFF_INT_ROUTING = 8'h3C;
   localparam logic [7:0] OFF_EXT_INT = 8'h48;
   localparam logic [7:0] OFF_HOT_SWAP = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // io window base fields
   localparam logic [31:0] IO_BASE_FIXED = 32'h0000_0001;
   localparam int IO_BASE_LSB = 8;
   localparam int IO_BASE_W = 24;

   ////////////////////////////////////////////////////////////////////////////
   // capability pointer and interrupt routing
   localparam logic [7:0] CAP_PTR_HOT_SWAP = 8'h80;
   localparam logic [7:0] INT_PIN_INTA = 8'h01;
   localparam int INT_LINE_W = 8;
   localparam int INT_PIN_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////
   // command / status word
   localparam int CMD_INT_DISABLE_BIT = 10;
   localparam int STAT_INT_STATUS_BIT = 19;
   localparam int STAT_CAP_LIST_BIT = 20;

   ////////////////////////////////////////////////////////////////////////////
   // external interrupt control / status
   localparam int EXT_INT_STATUS_BIT = 8;
   localparam int EXT_INT_ENABLE_BIT = 9;

   ////////////////////////////////////////////////////////////////////////////
   // hot-swap capability register
   localparam int HS_ENUM_MASK_BIT = 9;
   localparam int HS_LED_BIT = 11;
   localparam int HS_INS_STAT0_BIT = 14;
   localparam int HS_INS_STAT1_BIT = 15;
   localparam int HS_NEXT_LSB = 16;
   localparam int HS_CAP_ID_LSB = 24;
   localparam logic [7:0] HS_CAP_ID = 8'h06;
   localparam logic [7:0] HS_NEXT_PTR = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // configuration access from the host side
   typedef struct packed {
      logic [CFG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } pcicx_cfg_req_t;

   // open-drain interrupt pin
   typedef struct packed {
      logic out;
      logic oe_n;
   } pcicx_od_pin_t;

endpackage : pcicx_pkg

// File: hw/pcicx_sync3.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_i; output follows once
 * the second and third stages agree.
 */
`timescale 1ns/1ps

module pcicx_sync3
   import pcicx_pkg::*;
#(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // level in and out
   input wire logic async_i,
   output logic sync_o
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } pcicx_sync_state_t;

   pcicx_sync_state_t state;
   pcicx_sync_state_t next_state;

   always_comb begin
      next_state = state;
      if (ce_i) begin
         next_state.s1 = async_i;
         next_state.s2 = state.s1;
         next_state.s3 = state.s2;
         if (state.s2 == state.s3) begin
            next_state.level = state.s3;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.level;

endmodule : pcicx_sync3

// File: hw/pcicx_regs.sv
/*
 * Configuration extension registers of a PCI target: io window base with
 * address decode, capability pointer, interrupt routing, external interrupt
 * control/status, hot-swap capability, and the interrupt bits of the
 * command/status word.
 * Assumes the host bridge issues one-cycle read/write strobes on the config
 * port; read data stand the cycle after the read strobe.
 */
// What this block does
// - io window base bit 0 reads one, bit 1 zero, both read-only
// - io window base bits 7..2 read zero, ignore writes: 256-byte window
// - io window base bits 31..8 writable; io hit when equal to address 31..8
// - capability pointer low byte 80h with hot-swap, else zero; upper bits zero
// - capability pointer may be absent without hot-swap; then reads zero
// - interrupt line byte stores host writes, reads back, steers nothing
// - interrupt pin byte reads 01h, read-only, naming INTA
// - external interrupt status sets on active-low backend input, zero after reset
// - writing one to status bit 8 clears it; writing zero leaves it
// - bit 9 enables handling of the external interrupt input
// - external interrupt register bits 7..0 and 31..10 read zero
// - hot-swap bit 11 read/write, drives blue extraction indicator
// - hot-swap bits 31..24 read 06h, next-capability byte reads zero
// - command interrupt-disable bit blocks INTA, zero after reset
// - status bit 3 mirrors the INTA output state
`timescale 1ns/1ps

module pcicx_regs
   import pcicx_pkg::*;
#(
   parameter logic HOT_SWAP_EN = 1'b1
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // configuration port
   input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
   input wire logic [DATA_W-1:0] cfg_wdata_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   output logic [DATA_W-1:0] cfg_rdata_o,
   // io space decode
   input wire logic [DATA_W-1:0] io_addr_i,
   output logic io_hit_o,
   // backend interrupt
   input wire logic backend_interrupt_in_n_i,
   // interrupt pin, open drain
   output logic inta_n_o,
   output logic inta_oe_n_o,
   // hot-swap indicator
   output logic blue_led_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [IO_BASE_W-1:0] io_base;
      logic [INT_LINE_W-1:0] int_line;
      logic int_disable;
      logic ext_status;
      logic ext_enable;
      logic hs_enum_mask;
      logic hs_led;
      logic hs_ins_stat0;
      logic hs_ins_stat1;
      logic inta_active;
      logic [DATA_W-1:0] rdata;
   } pcicx_state_t;

   pcicx_state_t state;
   pcicx_state_t next_state;
   pcicx_cfg_req_t req;
   logic ext_int_level_n;

   assign req = '{addr: cfg_addr_i, wdata: cfg_wdata_i, wr: cfg_wr_i, rd: cfg_rd_i};

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // word select, low two address bits ignored
   function automatic logic reg_sel(input logic [CFG_ADDR_W-1:0] addr,
                                    input logic [CFG_ADDR_W-1:0] off);
      reg_sel = (addr[CFG_ADDR_W-1:2] == off[CFG_ADDR_W-1:2]);
   endfunction : reg_sel

   // write strobe to one register
   function automatic logic reg_wr(input pcicx_cfg_req_t r,
                                   input logic [CFG_ADDR_W-1:0] off);
      reg_wr = r.wr && reg_sel(r.addr, off);
   endfunction : reg_wr

   // io window compare on the programmable upper bits
   function automatic logic io_match(input logic [DATA_W-1:0] addr,
                                     input logic [IO_BASE_W-1:0] base);
      io_match = (addr[DATA_W-1:IO_BASE_LSB] == base);
   endfunction : io_match

   // read value for an address
   function automatic logic [DATA_W-1:0] reg_read(input pcicx_state_t s,
                                                  input logic [CFG_ADDR_W-1:0] addr,
                                                  input logic hs_en);
      logic [DATA_W-1:0] v;
      v = '0;
      if (reg_sel(addr, OFF_CMD_STATUS)) begin
         v[CMD_INT_DISABLE_BIT] = s.int_disable;
         v[STAT_INT_STATUS_BIT] = s.inta_active;
         v[STAT_CAP_LIST_BIT] = hs_en;
      end else if (reg_sel(addr, OFF_IO_BASE)) begin
         v = IO_BASE_FIXED;
         v[DATA_W-1:IO_BASE_LSB] = s.io_base;
      end else if (reg_sel(addr, OFF_CAP_PTR)) begin
         if (hs_en) begin
            v[$bits(CAP_PTR_HOT_SWAP)-1:0] = CAP_PTR_HOT_SWAP;
         end
      end else if (reg_sel(addr, OFF_INT_ROUTING)) begin
         v[INT_LINE_W-1:0] = s.int_line;
         v[INT_PIN_LSB +: $bits(INT_PIN_INTA)] = INT_PIN_INTA;
      end else if (reg_sel(addr, OFF_EXT_INT)) begin
         v[EXT_INT_STATUS_BIT] = s.ext_status;
         v[EXT_INT_ENABLE_BIT] = s.ext_enable;
      end else if (reg_sel(addr, OFF_HOT_SWAP) && hs_en) begin
         v[HS_ENUM_MASK_BIT] = s.hs_enum_mask;
         v[HS_LED_BIT] = s.hs_led;
         v[HS_INS_STAT0_BIT] = s.hs_ins_stat0;
         v[HS_INS_STAT1_BIT] = s.hs_ins_stat1;
         v[HS_NEXT_LSB +: $bits(HS_NEXT_PTR)] = HS_NEXT_PTR;
         v[HS_CAP_ID_LSB +: $bits(HS_CAP_ID)] = HS_CAP_ID;
      end
      reg_read = v;
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////////
   // backend interrupt input

   pcicx_sync3 #(
      .RESET_VAL(1'b1)
   ) u_ext_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .async_i(backend_interrupt_in_n_i),
      .sync_o(ext_int_level_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_state = state;
      if (ce_i) begin
         // command word interrupt disable
         if (reg_wr(req, OFF_CMD_STATUS)) begin
            next_state.int_disable = req.wdata[CMD_INT_DISABLE_BIT];
         end

         // io window base, low bits are constants
         if (reg_wr(req, OFF_IO_BASE)) begin
            next_state.io_base = req.wdata[DATA_W-1:IO_BASE_LSB];
         end

         // interrupt line byte, pin byte fixed
         if (reg_wr(req, OFF_INT_ROUTING)) begin
            next_state.int_line = req.wdata[INT_LINE_W-1:0];
         end

         // external interrupt enable and write-one-to-clear status
         if (reg_wr(req, OFF_EXT_INT)) begin
            next_state.ext_enable = req.wdata[EXT_INT_ENABLE_BIT];
            if (req.wdata[EXT_INT_STATUS_BIT]) begin
               next_state.ext_status = 1'b0;
            end
         end
         // set after clear so a coinciding event is kept
         if (!ext_int_level_n && state.ext_enable) begin
            next_state.ext_status = 1'b1;
         end

         // hot-swap control bits
         if (reg_wr(req, OFF_HOT_SWAP) && HOT_SWAP_EN) begin
            next_state.hs_enum_mask = req.wdata[HS_ENUM_MASK_BIT];
            next_state.hs_led = req.wdata[HS_LED_BIT];
            next_state.hs_ins_stat0 = req.wdata[HS_INS_STAT0_BIT];
            next_state.hs_ins_stat1 = req.wdata[HS_INS_STAT1_BIT];
         end

         // interrupt pin follows status, enable and disable
         next_state.inta_active = next_state.ext_status && next_state.ext_enable
                                  && !next_state.int_disable;

         // read data for the cycle after the strobe
         if (req.rd) begin
            next_state.rdata = reg_read(state, req.addr, HOT_SWAP_EN);
         end else begin
            next_state.rdata = '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   pcicx_od_pin_t inta_pin;

   always_comb begin
      inta_pin.out = 1'b0;
      inta_pin.oe_n = !state.inta_active;
   end

   assign inta_n_o = inta_pin.out;
   assign inta_oe_n_o = inta_pin.oe_n;
   assign cfg_rdata_o = state.rdata;
   assign io_hit_o = io_match(io_addr_i, state.io_base);
   assign blue_led_o = state.hs_led && HOT_SWAP_EN;

endmodule : pcicx_regs

// File: verification/pcicx_regs_properties.sv
/* port checker for pcicx_regs
   assumes ce_i may drop at any time; bound to every pcicx_regs instance */
`timescale 1ns/1ps
module pcicx_regs_chk
   import pcicx_pkg::*;
#(
   parameter logic HOT_SWAP_EN = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // configuration port
   input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
   input wire logic [DATA_W-1:0] cfg_wdata_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [DATA_W-1:0] cfg_rdata_o,
   // io decode, interrupt, indicator
   input wire logic [DATA_W-1:0] io_addr_i,
   input wire logic io_hit_o,
   input wire logic backend_interrupt_in_n_i,
   input wire logic inta_n_o,
   input wire logic inta_oe_n_o,
   input wire logic blue_led_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire [5:0] ra = cfg_addr_i[7:2];
   logic [23:0] base;
   logic led, en, dis;
   ////////////////////////////////////////////////////////////////////////////
   // shadows of host writes
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         base <= '0;
         led <= 1'b0;
         en <= 1'b0;
         dis <= 1'b0;
      end else if (cfg_wr_i && ce_i) begin
         if (ra == OFF_IO_BASE[7:2]) base <= cfg_wdata_i[31:8];
         if (ra == OFF_HOT_SWAP[7:2]) led <= cfg_wdata_i[11] & HOT_SWAP_EN;
         if (ra == OFF_EXT_INT[7:2]) en <= cfg_wdata_i[9];
         if (ra == OFF_CMD_STATUS[7:2]) dis <= cfg_wdata_i[10];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_io_low; cfg_rd_i && ce_i && ra == OFF_IO_BASE[7:2]
      |=> cfg_rdata_o[7:0] == 8'h01; endproperty
   a_io_low: assert property (p_io_low) else $error("io base low byte");
   property p_io_hit; io_hit_o == (io_addr_i[31:8] == base); endproperty
   a_io_hit: assert property (p_io_hit) else $error("io decode");
   property p_cap; cfg_rd_i && ce_i && ra == OFF_CAP_PTR[7:2]
      |=> cfg_rdata_o == {HOT_SWAP_EN, 7'h00}; endproperty
   a_cap: assert property (p_cap) else $error("capability pointer");
   property p_ext_rsv; cfg_rd_i && ce_i && ra == OFF_EXT_INT[7:2]
      |=> cfg_rdata_o[7:0] == 8'h00 && cfg_rdata_o[31:10] == 22'h0; endproperty
   a_ext_rsv: assert property (p_ext_rsv) else $error("ext int reserved bits");
   property p_hs_fix; cfg_rd_i && ce_i && ra == OFF_HOT_SWAP[7:2] && HOT_SWAP_EN
      |=> cfg_rdata_o[31:16] == 16'h0600 && (cfg_rdata_o[15:0] & 16'h35FF) == 16'h0; endproperty
   a_hs_fix: assert property (p_hs_fix) else $error("hot-swap fixed bits");
   property p_led; blue_led_o == led; endproperty
   a_led: assert property (p_led) else $error("blue indicator");
   property p_gate; !inta_oe_n_o |-> en && !dis && !inta_n_o; endproperty
   a_gate: assert property (p_gate) else $error("inta without enable");
   property p_set; (!backend_interrupt_in_n_i && ce_i && en && !dis) [*6] |-> !inta_oe_n_o;
   endproperty
   a_set: assert property (p_set) else $error("backend interrupt lost");
endmodule : pcicx_regs_chk

bind pcicx_regs pcicx_regs_chk #(.HOT_SWAP_EN(HOT_SWAP_EN)) u_pcicx_regs_chk (.clk_i,
   .reset_i, .ce_i, .cfg_addr_i, .cfg_wdata_i, .cfg_wr_i, .cfg_rd_i, .cfg_rdata_o,
   .io_addr_i, .io_hit_o, .backend_interrupt_in_n_i, .inta_n_o, .inta_oe_n_o, .blue_led_o);

// File: verification/pcicx_host.sv
/* host bridge model issuing configuration reads and writes
   assumes read data stand only in the cycle after the strobe */
`timescale 1ns/1ps
module pcicx_host
   import pcicx_pkg::*;
(
   // clock
   input wire logic clk_i,
   // configuration port
   output pcicx_cfg_req_t req_o,
   input wire logic [DATA_W-1:0] rdata_i
);
   initial req_o = '0;
   // released address and data show inverted values
   task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : cfg_write
   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: 32'hA5A5_5A5A, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_o <= '{addr: ~a, wdata: 32'h5A5A_A5A5, wr: 1'b0, rd: 1'b0};
      @(posedge clk_i);
      d = rdata_i;
   endtask : cfg_read
endmodule : pcicx_host

// File: verification/pcicx_regs_tb.sv
/* self-checking bench for pcicx_regs driven through the host model
   assumes the port checker is bound from its own file */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pcicx_regs_tb
   import pcicx_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic bk_n = 1'b1;
   logic hit, intn, oe_n, led, led_nh;
   logic [DATA_W-1:0] rdata, rdata_nh, d;
   logic [DATA_W-1:0] io_addr = '0;
   pcicx_cfg_req_t req;
   int num_errors = 0;
   int n_compared = 0;
   // open-drain line with pull-up
   wire inta_w = oe_n ? 1'b1 : intn;
   pcicx_regs u_pcicx_regs (.clk_i(clk), .reset_i(reset), .ce_i(ce), .cfg_addr_i(req.addr),
      .cfg_wdata_i(req.wdata), .cfg_wr_i(req.wr), .cfg_rd_i(req.rd), .cfg_rdata_o(rdata),
      .io_addr_i(io_addr), .io_hit_o(hit), .backend_interrupt_in_n_i(bk_n),
      .inta_n_o(intn), .inta_oe_n_o(oe_n), .blue_led_o(led));
   // second copy without the hot-swap capability, same stimulus
   pcicx_regs #(.HOT_SWAP_EN(1'b0)) u_pcicx_regs_nohs (.clk_i(clk), .reset_i(reset),
      .ce_i(ce), .cfg_addr_i(req.addr), .cfg_wdata_i(req.wdata), .cfg_wr_i(req.wr),
      .cfg_rd_i(req.rd), .cfg_rdata_o(rdata_nh), .io_addr_i(io_addr), .io_hit_o(),
      .backend_interrupt_in_n_i(bk_n), .inta_n_o(), .inta_oe_n_o(), .blue_led_o(led_nh));
   pcicx_host u_pcicx_host (.clk_i(clk), .req_o(req), .rdata_i(rdata));
   initial begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      u_pcicx_host.cfg_write(a, v);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [DATA_W-1:0] e0;
      // without hot-swap the capability words read zero and bit 20 is low
      e0 = e;
      if (a == OFF_CAP_PTR || a == OFF_HOT_SWAP) begin
         e0 = '0;
      end
      if (a == OFF_CMD_STATUS) begin
         e0[STAT_CAP_LIST_BIT] = 1'b0;
      end
      u_pcicx_host.cfg_read(a, d);
      `CHK($sformatf("read %h", a), e, d)
      `CHK($sformatf("read %h no hot-swap", a), e0, rdata_nh)
   endtask : rdchk
   task automatic t_reset();
      rdchk(OFF_IO_BASE, 32'h0000_0001);
      rdchk(OFF_CAP_PTR, 32'h0000_0080);
      rdchk(OFF_INT_ROUTING, 32'h0000_0100);
      rdchk(OFF_EXT_INT, 32'h0000_0000);
      rdchk(OFF_HOT_SWAP, 32'h0600_0000);
      rdchk(OFF_CMD_STATUS, 32'h0010_0000);
      rdchk(8'h60, 32'h0000_0000);
      `CHK("inta idle", 1'b1, inta_w)
      $display("reset test done");
   endtask : t_reset
   task automatic t_regs();
      wr(OFF_IO_BASE, 32'hFFFF_FFFF);
      rdchk(OFF_IO_BASE, 32'hFFFF_FF01);
      wr(OFF_IO_BASE, 32'h1234_56AA);
      rdchk(OFF_IO_BASE, 32'h1234_5601);
      io_addr <= 32'h1234_56FF;
      @(negedge clk);
      `CHK("io hit", 1'b1, hit)
      @(posedge clk);
      io_addr <= 32'h1234_5700;
      @(negedge clk);
      `CHK("io miss", 1'b0, hit)
      wr(OFF_CAP_PTR, 32'hFFFF_FFFF);
      rdchk(OFF_CAP_PTR, 32'h0000_0080);
      wr(OFF_INT_ROUTING, 32'hFFFF_FFA5);
      rdchk(OFF_INT_ROUTING, 32'h0000_01A5);
      wr(OFF_HOT_SWAP, 32'hFFFF_FFFF);
      rdchk(OFF_HOT_SWAP, 32'h0600_CA00);
      `CHK("led on", 1'b1, led)
      `CHK("led no hot-swap", 1'b0, led_nh)
      wr(OFF_HOT_SWAP, 32'h0000_0000);
      @(negedge clk);
      `CHK("led off", 1'b0, led)
      wr(OFF_EXT_INT, 32'hFFFF_FEFF);
      rdchk(OFF_EXT_INT, 32'h0000_0200);
      $display("register test done");
   endtask : t_regs
   task automatic t_int();
      bk_n <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("inta set", 1'b0, inta_w)
      rdchk(OFF_EXT_INT, 32'h0000_0300);
      rdchk(OFF_CMD_STATUS, 32'h0018_0000);
      wr(OFF_CMD_STATUS, 32'h0000_0400);
      @(negedge clk);
      `CHK("inta blocked", 1'b1, inta_w)
      wr(OFF_CMD_STATUS, 32'h0000_0000);
      bk_n <= 1'b1;
      repeat (6) @(posedge clk);
      wr(OFF_EXT_INT, 32'h0000_0200);
      rdchk(OFF_EXT_INT, 32'h0000_0300);
      wr(OFF_EXT_INT, 32'h0000_0300);
      @(negedge clk);
      `CHK("inta cleared", 1'b1, inta_w)
      rdchk(OFF_EXT_INT, 32'h0000_0200);
      wr(OFF_EXT_INT, 32'h0000_0000);
      bk_n <= 1'b0;
      repeat (8) @(posedge clk);
      rdchk(OFF_EXT_INT, 32'h0000_0000);
      bk_n <= 1'b1;
      $display("interrupt test done");
   endtask : t_int
   task automatic t_ce();
      // writes while the clock enable is low must be lost
      ce <= 1'b0;
      wr(OFF_INT_ROUTING, 32'h0000_005A);
      wr(OFF_HOT_SWAP, 32'h0000_0800);
      ce <= 1'b1;
      rdchk(OFF_INT_ROUTING, 32'h0000_01A5);
      rdchk(OFF_HOT_SWAP, 32'h0600_0000);
      `CHK("led frozen", 1'b0, led)
      $display("clock enable test done");
   endtask : t_ce
   task automatic t_rst2();
      wr(OFF_EXT_INT, 32'h0000_0200);
      bk_n <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("inta before reset", 1'b0, inta_w)
      wr(OFF_CMD_STATUS, 32'h0000_0400);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdchk(OFF_EXT_INT, 32'h0000_0000);
      rdchk(OFF_CMD_STATUS, 32'h0010_0000);
      rdchk(OFF_INT_ROUTING, 32'h0000_0100);
      `CHK("inta after reset", 1'b1, inta_w)
      bk_n <= 1'b1;
      $display("mid-run reset test done");
   endtask : t_rst2
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      #200us;
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_int();
      t_ce();
      t_rst2();
      stop_test();
   end
endmodule : pcicx_regs_tb
